// >>> core/csb_sfr_bank.sv
// core register bank with clock control, data pointers, serial control and data move sequencing
// assumes an APB master on sys_clk, core strobes on the same clock, port zero pin as three signals
// Operation
// - watchdog reset fires exactly 512 clocks after the watchdog interrupt point.
// - period select picks 2^17, 2^20, 2^23 or 2^26 clocks.
// - each timer ticks every 4 clocks when its select is 1, else 12.
// - stretch value n makes an external move last n plus 2 machine cycles.
// - on-chip RAM moves always take two machine cycles.
// - stretch field resets to 1, three machine cycle external moves.
// - serial control bit 7 is mode low bit or frame error by view select.
// - invalid stop bit sets frame error; it stays until software clears it.
// - serial mode bits pick sync 8-bit, async 10-bit, async 11-bit fixed or variable.
// - port zero is open drain when idle; in external moves it drives the address, then carries the data.
// - port zero pull-ups are on only while the pull-up enable bit is set.
// - stack pointer holds the current top of stack address.
// - low and high bytes form the first 16-bit data pointer, each accessible.
// - a second independent 16-bit data pointer sits in two more locations.
// - opcode a5 decrements the active data pointer.
// - on-chip data RAM answers only while its enable bit is set.
// - reset clears the on-chip RAM enable so all moves go external.
// - external write and read strobes drive port 3 bits 6 and 7.
// - on-chip data RAM is separate from the scratchpad RAM.
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps
module csb_sfr_bank #(
  parameter int WDT_BASE_EXP = 17, // shorten in simulation
  parameter int MC_CLKS = csb_pkg::MACH_CYCLE_CLKS
) (
  input wire logic sys_clk, // core clock, 100 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data, registered
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic op_valid, // core opcode strobe
  input wire logic [7:0] op_code, // core opcode
  input wire logic wdt_restart, // core restarts watchdog
  output logic wdt_irq, // watchdog interrupt level
  output logic wdt_reset, // watchdog reset pulse
  output logic [2:0] timer_tick, // per-timer count enables
  input wire logic frame_err_set, // receiver saw bad stop bit
  output logic [1:0] serial_mode, // selected serial mode
  output logic [3:0] serial_frame_bits, // frame length of the mode
  input wire logic move_req, // core starts a data move
  input wire logic move_write, // move direction
  input wire logic [15:0] move_addr, // move address
  input wire logic [7:0] move_wdata, // move write data
  output logic move_busy, // move in progress
  output logic move_done, // move finished, one cycle
  output logic [7:0] move_rdata, // move read data
  output logic [15:0] dptr_active, // selected data pointer
  output logic [7:0] stack_top, // stack pointer
  input wire logic [7:0] p0_in, // port zero pin level
  output logic [7:0] p0_out, // port zero drive value
  output logic [7:0] p0_oe, // port zero drive enable
  output logic p0_pullup_en, // port zero weak pull-ups
  output logic p3_wr_n, // port 3 bit 6 write strobe
  output logic p3_rd_n // port 3 bit 7 read strobe
);
  typedef enum {CSB_MV_IDLE, CSB_MV_RUN} csb_mv_t;
  // one clock domain: the checks share this clock and reset
  default clocking chk_cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic [7:0] port_zero_latch, stack_top_pointer, data_ptr_a_low, data_ptr_a_high;
  logic [7:0] data_ptr_b_low, data_ptr_b_high, clock_and_stretch_control, serial_zero_control;
  logic [7:0] core_misc, power_control_reg, port_four_polarity_reg, power_mgmt_reg;
  logic frame_err;
  logic [7:0] p0_sync1, p0_sync2;
  logic [7:0] xram [csb_pkg::XRAM_WORDS];

  // apb decode
  wire logic [7:0] reg_idx = paddr[9:2];
  wire logic in_range = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
  wire logic wr_en = psel && penable && pwrite;
  wire logic hit_p0 = in_range && reg_idx == csb_pkg::IDX_PORT_ZERO;
  wire logic hit_sp = in_range && reg_idx == csb_pkg::IDX_STACK_TOP;
  wire logic hit_al = in_range && reg_idx == csb_pkg::IDX_DPTR_A_LO;
  wire logic hit_ah = in_range && reg_idx == csb_pkg::IDX_DPTR_A_HI;
  wire logic hit_bl = in_range && reg_idx == csb_pkg::IDX_DPTR_B_LO;
  wire logic hit_bh = in_range && reg_idx == csb_pkg::IDX_DPTR_B_HI;
  wire logic hit_misc = in_range && reg_idx == csb_pkg::IDX_CORE_MISC;
  wire logic hit_power_control_reg = in_range && reg_idx == csb_pkg::IDX_POWER_CTL;
  wire logic hit_clk = in_range && reg_idx == csb_pkg::IDX_CLOCK_CTL;
  wire logic hit_serial_zero_control = in_range && reg_idx == csb_pkg::IDX_SERIAL_CTL;
  wire logic hit_p4p = in_range && reg_idx == csb_pkg::IDX_P4_POLARITY;
  wire logic hit_pmr = in_range && reg_idx == csb_pkg::IDX_POWER_MGMT;
  wire logic mapped = hit_p0 | hit_sp | hit_al | hit_ah | hit_bl | hit_bh | hit_misc | hit_power_control_reg |
                      hit_clk | hit_serial_zero_control | hit_p4p | hit_pmr;
  wire logic fe_view = power_control_reg[csb_pkg::POWER_CONTROL_REG_FE_VIEW_BIT];
  wire logic [7:0] serial_zero_control_view = {fe_view ? frame_err : serial_zero_control[7], serial_zero_control[6:0]};
  wire logic [7:0] rd_mux = hit_p0 ? p0_sync2 : hit_sp ? stack_top_pointer :
                            hit_al ? data_ptr_a_low : hit_ah ? data_ptr_a_high :
                            hit_bl ? data_ptr_b_low : hit_bh ? data_ptr_b_high :
                            hit_misc ? core_misc : hit_power_control_reg ? power_control_reg :
                            hit_clk ? clock_and_stretch_control : hit_serial_zero_control ? serial_zero_control_view :
                            hit_p4p ? port_four_polarity_reg : hit_pmr ? power_mgmt_reg : 8'h00;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // read data captured in setup so it stands through the access phase
  always_ff @(posedge sys_clk) begin
    if (rst) prdata <= 32'h0;
    else if (psel && !penable) prdata <= {24'h0, rd_mux};
  end

  // data pointer decrement and selection
  wire logic ptr_sel = core_misc[csb_pkg::MISC_DPTR_SEL_BIT];
  wire logic dec_op = op_valid && op_code == csb_pkg::OP_DPTR_DEC;
  wire logic [15:0] ptr_a = {data_ptr_a_high, data_ptr_a_low};
  wire logic [15:0] ptr_b = {data_ptr_b_high, data_ptr_b_low};
  wire logic [15:0] ptr_a_dec = ptr_a - 16'h1;
  wire logic [15:0] ptr_b_dec = ptr_b - 16'h1;
  assign dptr_active = ptr_sel ? ptr_b : ptr_a;
  assign stack_top = stack_top_pointer;

  // byte registers written over apb; a software write beats the decrement of the written pointer byte only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      port_zero_latch <= 8'hff;
      stack_top_pointer <= 8'h07;
      data_ptr_a_low <= 8'h00;
      data_ptr_a_high <= 8'h00;
      data_ptr_b_low <= 8'h00;
      data_ptr_b_high <= 8'h00;
      core_misc <= 8'h00;
      power_control_reg <= 8'h00;
      port_four_polarity_reg <= 8'h00;
      power_mgmt_reg <= 8'h00;
      clock_and_stretch_control <= csb_pkg::CLK_RESET;
    end else begin
      if (wr_en && hit_p0) port_zero_latch <= pwdata[7:0];
      if (wr_en && hit_sp) stack_top_pointer <= pwdata[7:0];
      if (wr_en && hit_al) data_ptr_a_low <= pwdata[7:0];
      else if (dec_op && !ptr_sel) data_ptr_a_low <= ptr_a_dec[7:0];
      if (wr_en && hit_ah) data_ptr_a_high <= pwdata[7:0];
      else if (dec_op && !ptr_sel) data_ptr_a_high <= ptr_a_dec[15:8];
      if (wr_en && hit_bl) data_ptr_b_low <= pwdata[7:0];
      else if (dec_op && ptr_sel) data_ptr_b_low <= ptr_b_dec[7:0];
      if (wr_en && hit_bh) data_ptr_b_high <= pwdata[7:0];
      else if (dec_op && ptr_sel) data_ptr_b_high <= ptr_b_dec[15:8];
      if (wr_en && hit_misc) core_misc <= {6'h0, pwdata[1:0]};
      if (wr_en && hit_power_control_reg) power_control_reg <= pwdata[7:0];
      if (wr_en && hit_p4p) port_four_polarity_reg <= pwdata[7:0];
      if (wr_en && hit_pmr) power_mgmt_reg <= pwdata[7:0];
      if (wr_en && hit_clk) clock_and_stretch_control <= pwdata[7:0];
    end
  end

  // serial control: bit 7 lands in the mode bit or the error flag by view select
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      serial_zero_control <= 8'h00;
      frame_err <= 1'b0;
    end else begin
      if (wr_en && hit_serial_zero_control) serial_zero_control <= {fe_view ? serial_zero_control[7] : pwdata[7], pwdata[6:0]};
      // hardware set beats a software clear in the same cycle
      if (frame_err_set) frame_err <= 1'b1;
      else if (wr_en && hit_serial_zero_control && fe_view) frame_err <= pwdata[7];
    end
  end
  assign serial_mode = {serial_zero_control[csb_pkg::SER_MODE_LOW_BIT], serial_zero_control[csb_pkg::SER_MODE_HIGH_BIT]};
  // frame length per mode
  assign serial_frame_bits = (serial_mode == csb_pkg::CSB_SER_SYNC8) ? 4'h8 :
                             (serial_mode == csb_pkg::CSB_SER_ASYNC10) ? 4'ha : 4'hb;

  // timer prescalers: one shared divider per rate, selected per timer
  logic [1:0] div4_cnt;
  logic [3:0] div12_cnt;
  wire logic tick4 = div4_cnt == 2'(csb_pkg::PRESCALE_FAST - 1);
  wire logic tick12 = div12_cnt == 4'(csb_pkg::PRESCALE_SLOW - 1);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div4_cnt <= 2'h0;
      div12_cnt <= 4'h0;
    end else begin
      div4_cnt <= tick4 ? 2'h0 : div4_cnt + 2'h1;
      div12_cnt <= tick12 ? 4'h0 : div12_cnt + 4'h1;
    end
  end
  wire logic [2:0] tmr_sel = {clock_and_stretch_control[csb_pkg::CLK_T2M_BIT],
                              clock_and_stretch_control[csb_pkg::CLK_T1M_BIT],
                              clock_and_stretch_control[csb_pkg::CLK_T0M_BIT]};
  for (genvar t = 0; t < 3; t++) begin : g_tick
    assign timer_tick[t] = tmr_sel[t] ? tick4 : tick12;
  end

  // watchdog: interrupt at 2^(base+3*sel), reset a fixed 512 clocks later
  logic [27:0] wdt_cnt;
  wire logic [1:0] wdt_sel = clock_and_stretch_control[csb_pkg::CLK_WDT_LSB +: 2];
  wire logic [27:0] wdt_irq_pt = 28'h1 << (WDT_BASE_EXP + csb_pkg::WDT_EXP_STEP * int'(wdt_sel));
  wire logic [27:0] wdt_rst_pt = wdt_irq_pt + 28'(csb_pkg::WDT_RESET_EXTRA);
  wire logic wdt_run = core_misc[csb_pkg::MISC_WDT_RUN_BIT];
  always_ff @(posedge sys_clk) begin
    if (rst || wdt_restart || !wdt_run || wdt_reset) wdt_cnt <= 28'h0;
    else wdt_cnt <= wdt_cnt + 28'h1;
  end
  assign wdt_irq = wdt_cnt >= wdt_irq_pt;
  assign wdt_reset = wdt_cnt == wdt_rst_pt;

  // data move sequencer; the stretch is latched at start so a later write waits
  csb_mv_t mv_state;
  logic [7:0] mv_left, mv_len;
  logic mv_onchip, mv_write;
  logic [15:0] mv_addr;
  logic [7:0] mv_wdata;
  wire logic [2:0] stretch = clock_and_stretch_control[csb_pkg::CLK_MD_LSB +: 3];
  wire logic xram_en = power_mgmt_reg[csb_pkg::PMR_XRAM_EN_BIT];
  wire logic hit_xram = xram_en && move_addr < 16'(csb_pkg::XRAM_WORDS);
  wire logic mv_start = mv_state == CSB_MV_IDLE && move_req;
  wire logic [3:0] mv_mcs = hit_xram ? 4'(csb_pkg::MOVE_BASE_CYCLES) : 4'(csb_pkg::MOVE_BASE_CYCLES) + {1'b0, stretch};
  wire logic [7:0] mv_total = 8'(int'(mv_mcs) * MC_CLKS);
  wire logic addr_phase = mv_len - mv_left < 8'(MC_CLKS);
  wire logic ext_run = mv_state == CSB_MV_RUN && !mv_onchip;
  assign move_busy = mv_state == CSB_MV_RUN;
  assign move_done = mv_state == CSB_MV_RUN && mv_left == 8'h1;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mv_state <= CSB_MV_IDLE;
      mv_left <= 8'h0;
      mv_len <= 8'h0;
      mv_onchip <= 1'b0;
      mv_write <= 1'b0;
      mv_addr <= 16'h0;
      mv_wdata <= 8'h0;
    end else begin
      unique case (mv_state)
        CSB_MV_IDLE: if (move_req) begin
          mv_state <= CSB_MV_RUN;
          mv_left <= mv_total;
          mv_len <= mv_total;
          mv_onchip <= hit_xram;
          mv_write <= move_write;
          mv_addr <= move_addr;
          mv_wdata <= move_wdata;
        end
        CSB_MV_RUN: begin
          mv_left <= mv_left - 8'h1;
          if (mv_left == 8'h1) mv_state <= CSB_MV_IDLE;
        end
      endcase
    end
  end

  // on-chip data ram, separate from the scratchpad
  always_ff @(posedge sys_clk) begin
    if (mv_start && hit_xram && move_write) xram[move_addr[csb_pkg::XRAM_AW-1:0]] <= move_wdata;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) move_rdata <= 8'h00;
    else if (mv_start && hit_xram && !move_write) move_rdata <= xram[move_addr[csb_pkg::XRAM_AW-1:0]];
    else if (ext_run && !mv_write && mv_left == 8'h1) move_rdata <= p0_sync2;
  end

  // port zero pins, synchronised in; open drain when idle, bus driver during an external move
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      p0_sync1 <= 8'h00;
      p0_sync2 <= 8'h00;
      p0_out <= 8'h00;
      p0_oe <= 8'h00;
      p3_wr_n <= 1'b1;
      p3_rd_n <= 1'b1;
    end else begin
      p0_sync1 <= p0_in;
      p0_sync2 <= p0_sync1;
      p0_out <= ext_run ? (addr_phase ? mv_addr[7:0] : mv_wdata) : 8'h00;
      p0_oe <= ext_run ? ((addr_phase || mv_write) ? 8'hff : 8'h00) : ~port_zero_latch;
      p3_wr_n <= !(ext_run && mv_write && !addr_phase && mv_left > 8'h1);
      p3_rd_n <= !(ext_run && !mv_write && !addr_phase && mv_left > 8'h1);
    end
  end
  assign p0_pullup_en = port_four_polarity_reg[csb_pkg::P4P_PULLUP_BIT];

  // helper counters for the checks below
  logic [9:0] irq_age;
  logic [7:0] mv_age;
  always_ff @(posedge sys_clk) begin
    if (rst || !wdt_irq) irq_age <= 10'h0;
    else irq_age <= irq_age + 10'h1;
    if (rst || mv_start) mv_age <= 8'h1;
    else if (move_busy) mv_age <= mv_age + 8'h1;
  end
  // stretch as it stood when each move was taken, for the length check
  logic [2:0] mv_str_seen;
  always_ff @(posedge sys_clk) begin
    if (rst) mv_str_seen <= 3'h0;
    else if (mv_start) mv_str_seen <= stretch;
  end

  sequence s_fast_gap;
    !tick4[*3] ##1 tick4;
  endsequence
  sequence s_slow_gap;
    !tick12[*8] ##1 !tick12[*3] ##1 tick12;
  endsequence

  wdt_reset_gap_a: assert property (@(posedge sys_clk) disable iff (rst) wdt_reset |-> irq_age == 10'd512)
    else $error("watchdog reset not 512 clocks after interrupt");
  wdt_irq_point_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(wdt_irq) |-> wdt_cnt == (28'h1 << (WDT_BASE_EXP + 3 * int'(wdt_sel))))
    else $error("watchdog interrupt at wrong count");
  tick_fast_a: assert property (@(posedge sys_clk) disable iff (rst) tick4 |=> s_fast_gap)
    else $error("divide by 4 tick spacing wrong");
  tick_slow_a: assert property (@(posedge sys_clk) disable iff (rst) tick12 |=> s_slow_gap)
    else $error("divide by 12 tick spacing wrong");
  move_length_a: assert property (@(posedge sys_clk) disable iff (rst)
    move_done |-> mv_age == 8'((mv_onchip ? 2 : 2 + int'(mv_str_seen)) * MC_CLKS))
    else $error("move length wrong");
  onchip_two_a: assert property (@(posedge sys_clk) disable iff (rst)
    (mv_start && hit_xram) |=> mv_len == 8'(2 * MC_CLKS))
    else $error("on-chip move not two machine cycles");
  stretch_reset_a: assert property (@(posedge sys_clk) $past(rst) |-> stretch == 3'h1 && !xram_en)
    else $error("stretch or ram enable reset value wrong");
  frame_err_view_a: assert property (@(posedge sys_clk) disable iff (rst)
    frame_err_set |=> frame_err && (!fe_view || serial_zero_control_view[7]))
    else $error("frame error not set or not shown");
  move_stable_a: assert property (@(posedge sys_clk) disable iff (rst)
    (move_busy && !move_done) |=> $stable(mv_len))
    else $error("move length changed mid move");
  strobe_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
    !p3_rd_n |-> $past(ext_run) && !$past(mv_write))
    else $error("read strobe outside external read");
  ram_enable_a: assert property (@(posedge sys_clk) disable iff (rst)
    (mv_start && !xram_en) |=> !mv_onchip)
    else $error("on-chip ram answered while disabled");

  // more checks on the default clock
  ptr_a_dec_a: assert property (
    (dec_op && !ptr_sel && !wr_en) |=> ptr_a == $past(ptr_a) - 16'h1)
    else $error("pointer a not decremented");
  ptr_b_own_a: assert property (
    (dec_op && ptr_sel && !wr_en) |=> ptr_b == $past(ptr_b) - 16'h1 && $stable(ptr_a))
    else $error("pointer b not decremented alone");
  stack_write_a: assert property (
    (wr_en && hit_sp) |=> stack_top == $past(pwdata[7:0]))
    else $error("stack pointer write lost");
  pullup_write_a: assert property (
    (wr_en && hit_p4p) |=> p0_pullup_en == $past(pwdata[0]))
    else $error("pull-up enable wrong");
  mode_bit_kept_a: assert property (
    (wr_en && hit_serial_zero_control && fe_view) |=> $stable(serial_mode[1]))
    else $error("mode bit written while error shown");
  frame_err_hold_a: assert property (
    (frame_err && !(wr_en && hit_serial_zero_control && fe_view)) |=> frame_err)
    else $error("frame error dropped without a clear");
  frame_len_a: assert property (
    serial_frame_bits == (serial_mode[1] ? 4'hb : serial_mode[0] ? 4'ha : 4'h8))
    else $error("frame length wrong for mode");
  write_gate_a: assert property (
    !p3_wr_n |-> $past(ext_run) && $past(mv_write))
    else $error("write strobe outside external write");
  p0_idle_a: assert property (
    !$past(ext_run) |-> p0_out == 8'h00)
    else $error("port zero drives high when idle");
  p0_addr_a: assert property (
    ($past(ext_run) && $past(addr_phase)) |-> p0_oe == 8'hff && p0_out == $past(mv_addr[7:0]))
    else $error("address byte not driven");
  onchip_quiet_a: assert property (
    (move_busy && mv_onchip) |=> p3_rd_n && p3_wr_n)
    else $error("strobe during on-chip move");
  move_hold_a: assert property (
    (move_busy && !move_done) |=> $stable(mv_addr) && $stable(mv_write))
    else $error("move changed while running");
  wdt_restart_a: assert property (
    wdt_reset |=> !wdt_irq)
    else $error("watchdog not restarted after reset");
endmodule // csb_sfr_bank

// >>> core/csb_pkg.sv
// constants of the core register bank: register indices, field positions, reset values, timing
// assumes a 100 MHz core clock; byte address of a register is four times its index
package csb_pkg;
  // register indices (byte address = index * 4)
  localparam logic [7:0] IDX_PORT_ZERO = 8'h80;
  localparam logic [7:0] IDX_STACK_TOP = 8'h81;
  localparam logic [7:0] IDX_DPTR_A_LO = 8'h82;
  localparam logic [7:0] IDX_DPTR_A_HI = 8'h83;
  localparam logic [7:0] IDX_DPTR_B_LO = 8'h84;
  localparam logic [7:0] IDX_DPTR_B_HI = 8'h85;
  localparam logic [7:0] IDX_CORE_MISC = 8'h86;
  localparam logic [7:0] IDX_POWER_CTL = 8'h87;
  localparam logic [7:0] IDX_CLOCK_CTL = 8'h8e;
  localparam logic [7:0] IDX_SERIAL_CTL = 8'h98;
  localparam logic [7:0] IDX_P4_POLARITY = 8'ha2;
  localparam logic [7:0] IDX_POWER_MGMT = 8'hc4;
  // clock control fields
  localparam int CLK_WDT_LSB = 6;
  localparam int CLK_T2M_BIT = 5;
  localparam int CLK_T1M_BIT = 4;
  localparam int CLK_T0M_BIT = 3;
  localparam int CLK_MD_LSB = 0;
  localparam logic [7:0] CLK_RESET = 8'h01;
  // other field positions
  localparam int SER_MODE_LOW_BIT = 7;
  localparam int SER_MODE_HIGH_BIT = 6;
  localparam int POWER_CONTROL_REG_FE_VIEW_BIT = 6;
  localparam int P4P_PULLUP_BIT = 0;
  localparam int PMR_XRAM_EN_BIT = 0;
  localparam int MISC_DPTR_SEL_BIT = 0;
  localparam int MISC_WDT_RUN_BIT = 1;
  // opcodes and sizes
  localparam logic [7:0] OP_DPTR_DEC = 8'ha5;
  localparam int XRAM_WORDS = 1024;
  localparam int XRAM_AW = 10;
  // watchdog, prescale and move timing, in core clocks except the move base in machine cycles
  localparam int WDT_RESET_EXTRA = 512;
  localparam int WDT_EXP_STEP = 3;
  localparam int PRESCALE_FAST = 4;
  localparam int PRESCALE_SLOW = 12;
  localparam int MOVE_BASE_CYCLES = 2;
  localparam int MACH_CYCLE_CLKS = 4;
  // serial mode codes
  typedef enum logic [1:0] {CSB_SER_SYNC8, CSB_SER_ASYNC10, CSB_SER_ASYNC11_FIX, CSB_SER_ASYNC11_VAR} csb_ser_mode_t;
endpackage

// >>> dv/csb_sfr_bank_test.sv
// self-checking bench for the core register bank: apb access, moves, pointers, timers, watchdog, serial control
// assumes the bank stands alone; the bench plays apb master, core and serial receiver on one 100 MHz clock
`timescale 1ns/100ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin fail_count++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end
module csb_sfr_bank_test;
  localparam int WEXP = 4; // short watchdog so the longest period fits the run
  logic sys_clk, rst, psel, penable, pwrite, op_valid, wdt_restart, frame_err_set, move_req, move_write;
  logic pready, pslverr, wdt_irq, wdt_reset, move_busy, move_done, p0_pullup_en, p3_wr_n, p3_rd_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] op_code, move_wdata, move_rdata, stack_top, p0_in, p0_out, p0_oe, rd, lastw;
  logic [2:0] timer_tick;
  logic [1:0] serial_mode;
  logic [3:0] serial_frame_bits;
  logic [15:0] move_addr, dptr_active, ptr;
  logic [7:0] mdl [0:255]; // register model by index
  logic err;
  int fail_count, compares, n, g0, t0;
  bit saw_wr, saw_rd, saw_adr;
  int fb [4] = '{8, 10, 11, 11};

  csb_sfr_bank #(.WDT_BASE_EXP(WEXP)) dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_valid(op_valid), .op_code(op_code), .wdt_restart(wdt_restart), .wdt_irq(wdt_irq), .wdt_reset(wdt_reset),
    .timer_tick(timer_tick), .frame_err_set(frame_err_set), .serial_mode(serial_mode),
    .serial_frame_bits(serial_frame_bits), .move_req(move_req), .move_write(move_write), .move_addr(move_addr),
    .move_wdata(move_wdata), .move_busy(move_busy), .move_done(move_done), .move_rdata(move_rdata),
    .dptr_active(dptr_active), .stack_top(stack_top), .p0_in(p0_in), .p0_out(p0_out), .p0_oe(p0_oe),
    .p0_pullup_en(p0_pullup_en), .p3_wr_n(p3_wr_n), .p3_rd_n(p3_rd_n));

  // free-running core clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // one apb transfer; request held until pready is seen high at a rising edge
  task automatic apb(input bit wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    // no wait limit here: the bench watchdog ends a hang
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wreg(input logic [7:0] idx, input logic [7:0] v);
    apb(1'b1, idx, v);
    mdl[idx] = v;
  endtask
  task automatic rchk(input logic [7:0] idx);
    apb(1'b0, idx, 8'h00);
    `CHK(rd, mdl[idx])
  endtask
  // one data move; counts edges from the taking edge to move_done, watching strobes and port zero
  task automatic mv(input bit w, input logic [15:0] a);
    @(posedge sys_clk);
    lastw = w ? 8'($urandom) : lastw;
    move_req <= 1'b1;
    move_write <= w;
    move_addr <= a;
    move_wdata <= lastw;
    @(posedge sys_clk);
    move_req <= 1'b0;
    {n, saw_wr, saw_rd, saw_adr} = '0;
    do begin
      @(posedge sys_clk);
      n++;
      saw_wr |= (p3_wr_n === 1'b0);
      saw_rd |= (p3_rd_n === 1'b0);
      saw_adr |= (p0_oe === 8'hff && p0_out === a[7:0]);
    end while (move_done !== 1'b1 && n < 100);
  endtask
  // edges between two consecutive ticks of one timer
  task automatic gap(input int i);
    n = 0;
    do @(posedge sys_clk); while (timer_tick[i] !== 1'b1 && ++n < 50);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (timer_tick[i] !== 1'b1 && n < 50);
  endtask
  task automatic pulse_op(input logic [7:0] code);
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op_code <= code;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic stop_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // watchdog on the bench: the whole run needs well under 20000 cycles
  initial begin
    #200us;
    fail_count++;
    stop_test();
  end

  initial begin
    {rst, psel, penable, pwrite, op_valid, wdt_restart, frame_err_set, move_req, move_write} = 9'h100;
    {paddr, pwdata, op_code, move_wdata, move_addr, lastw} = '0;
    void'($urandom(77));
    p0_in = 8'($urandom);
    foreach (mdl[i]) mdl[i] = 8'h00;
    {mdl[8'h80], mdl[8'h81], mdl[8'h8e]} = {p0_in, 8'h07, 8'h01}; // port zero reads its pins
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk); // pins need two edges through the synchroniser
    // reset values, then a refused unmapped access
    foreach (fb[i]) rchk(8'h80 + 8'(i));
    foreach (fb[i]) rchk(8'h84 + 8'(i));
    rchk(8'h8e);
    rchk(8'hc4);
    apb(1'b0, 8'h90, 8'h00);
    `CHK({err, rd}, 9'h100)
    $display("done reset values");
    // both pointers and the stack, byte by byte, then decrement with borrow
    for (int i = 8'h81; i <= 8'h85; i++) wreg(8'(i), 8'($urandom));
    wreg(8'h84, 8'h00);
    rchk(8'h82);
    rchk(8'h83);
    `CHK(stack_top, mdl[8'h81])
    `CHK(dptr_active, {mdl[8'h83], mdl[8'h82]})
    wreg(8'h86, 8'h01);
    @(posedge sys_clk);
    `CHK(dptr_active, {mdl[8'h85], mdl[8'h84]})
    pulse_op(8'ha5);
    ptr = {mdl[8'h85], mdl[8'h84]} - 16'h1;
    {mdl[8'h85], mdl[8'h84]} = ptr;
    `CHK(dptr_active, ptr)
    rchk(8'h84);
    rchk(8'h85);
    rchk(8'h82);
    wreg(8'h86, 8'h00);
    $display("done data pointers");
    // external moves: default stretch, then every stretch value
    mv(1'b1, 16'h1234);
    `CHK(n, 12)
    `CHK({saw_wr, saw_rd, saw_adr}, 3'b101)
    for (int s = 0; s < 8; s++) begin
      wreg(8'h8e, 8'(s));
      mv(1'b0, 16'h8000 + 16'(s));
      `CHK(n, (s + 2) * 4)
      `CHK({saw_wr, saw_rd}, 2'b01)
      @(posedge sys_clk);
      `CHK(move_rdata, p0_in)
    end
    // on-chip moves ignore the stretch; from 1K up and when disabled they go out
    wreg(8'hc4, 8'h01);
    mv(1'b1, 16'h03ff);
    `CHK(n, 8)
    `CHK({saw_wr, saw_rd}, 2'b00)
    mv(1'b0, 16'h03ff);
    @(posedge sys_clk);
    `CHK(move_rdata, lastw)
    mv(1'b0, 16'h0400);
    `CHK(n, 36)
    wreg(8'hc4, 8'h00);
    mv(1'b0, 16'h03ff);
    `CHK(n, 36)
    $display("done data moves");
    // timer prescalers, all three slow then all three fast
    for (int f = 0; f < 2; f++) begin
      wreg(8'h8e, f ? 8'h39 : 8'h01);
      for (int i = 0; i < 3; i++) begin
        gap(i);
        `CHK(n, f ? 4 : 12)
      end
    end
    $display("done timer prescale");
    // watchdog periods relative to the shortest, and reset 512 clocks after the interrupt
    wreg(8'h86, 8'h02);
    for (int s = 0; s < 4; s++) begin
      wreg(8'h8e, {2'(s), 6'h01});
      @(posedge sys_clk);
      wdt_restart <= 1'b1;
      @(posedge sys_clk);
      wdt_restart <= 1'b0;
      t0 = 0;
      do begin
        @(posedge sys_clk);
        t0++;
      end while (wdt_irq !== 1'b1 && t0 < 20000);
      if (s == 0) g0 = t0;
      `CHK(t0 - g0, (1 << (WEXP + 3 * s)) - (1 << WEXP))
      n = 0;
      do begin
        @(posedge sys_clk);
        n++;
      end while (wdt_reset !== 1'b1 && n < 1000);
      `CHK(n, 512)
    end
    wreg(8'h86, 8'h00);
    $display("done watchdog");
    // serial modes, then the frame error view
    for (int m = 0; m < 4; m++) begin
      wreg(8'h98, {2'(m), 6'h00});
      @(posedge sys_clk);
      `CHK(serial_mode, 2'(m))
      `CHK(serial_frame_bits, 4'(fb[m]))
    end
    wreg(8'h98, 8'h00);
    wreg(8'h87, 8'h40);
    @(posedge sys_clk);
    frame_err_set <= 1'b1;
    @(posedge sys_clk);
    frame_err_set <= 1'b0;
    mdl[8'h98] = 8'h80;
    rchk(8'h98);
    `CHK(serial_mode, 2'b00)
    rchk(8'h98);
    wreg(8'h98, 8'h00);
    rchk(8'h98);
    wreg(8'h87, 8'h00);
    $display("done serial control");
    // port zero pull-ups follow their enable bit
    wreg(8'ha2, 8'h01);
    @(posedge sys_clk);
    `CHK(p0_pullup_en, 1'b1)
    wreg(8'ha2, 8'h00);
    @(posedge sys_clk);
    `CHK(p0_pullup_en, 1'b0)
    // idle port zero only pulls low where its latch holds zero
    apb(1'b1, 8'h80, 8'h5a);
    repeat (2) @(posedge sys_clk);
    `CHK({p0_oe, p0_out}, 16'ha500)
    $display("done pull-ups");
    stop_test();
  end
endmodule // csb_sfr_bank_test
